// ===== rtl/scw_top.v
// Functional notes
// - Drive reset pin low, open drain, 25 to 75 ms after power-up.
// - After power-on period release reset pin; external pull-up restores high.
// - External reset fall with output enabled: drive reset low 16 cycles.
// - External wait looked at only after internal waits, except daisy wait.
// - Insert zero to three programmed wait states into memory accesses.
// - Optional extra wait state during opcode fetch cycles.
// - Programmed memory waits only inside the memory wait address range; fetch wait anywhere.
// - Range is low nibble up to high nibble; reset covers all addresses.
// - Insert 0, 2, 4 or 6 wait states into I/O accesses.
// - No I/O waits for on-chip peripheral addresses.
// - Optional one vector wait after I/O strobe in interrupt acknowledge.
// - 0, 2, 4 or 6 daisy waits between fetch marker and I/O strobe.
// - Daisy setting 4 or 6: return sequence gets 2 or 4 waits.
// - If opcode after prefix is not the return opcode, insert one wait.
// - Each chip select compares its 4-bit bound with upper address nibble.
// - Low bank select when nibble at most chip select low bound.
// - Upper bank select when above low bound, at most high bound.
// - Separate enables; low bank enabled with bound F at power-up.
// - Upper bank select disabled at power-up; its bound ignored.
// - Registers reached via pointer port EEh, then data port EFh.
// - Index 00 wait control, 01 memory bounds, 02 cs bounds, 03 misc.
`timescale 1ns/100ps
`include "scw_regs.vh"
module scw_top #(
  parameter POR_CYCLES = `SCW_POR_CYCLES,
  parameter POR_CNT_W  = 22
) (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire [15:0] cpu_addr_i,
  input  wire [7:0]  cpu_data_i,
  input  wire        cpu_mreq_n_i,
  input  wire        io_request_strobe_n_i,
  input  wire        cpu_rd_n_i,
  input  wire        cpu_wr_n_i,
  input  wire        opcode_fetch_marker_n_i,
  input  wire        ext_wait_n_i,
  input  wire        reset_pin_i,
  output wire        reset_pin_o,
  output wire        reset_pin_oe_o,
  output wire        cpu_reset_n_o,
  output wire        cpu_wait_n_o,
  output reg  [7:0]  io_rdata_o,
  output wire        io_rdata_en_o,
  output wire        low_bank_select_n_o,
  output wire        upper_bank_select_n_o,
  output wire        clock_div1_o
);
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_MEM   = 3'd1;
  localparam [2:0] ST_IO    = 3'd2;
  localparam [2:0] ST_DAISY = 3'd3;
  localparam [2:0] ST_VECT  = 3'd4;

  reg        rst_s1_q;
  reg        rst_s2_q;
  reg        ewait_s1_q;
  reg        ewait_s2_q;
  reg        mreq_l_q;
  reg        io_request_strobe_l_q;
  reg        m1_l_q;
  reg        wr_l_q;
  reg  [7:0] ptr_q;
  reg  [7:0] wait_ctl_q;
  reg  [7:0] mwb_q;
  reg  [7:0] csb_q;
  reg  [7:0] misc_q;
  reg  [2:0] st_q;
  reg  [2:0] st_d;
  reg  [3:0] cnt_q;
  reg  [3:0] cnt_d;
  reg  [7:0] op_q;
  reg        ed_seen_q;
  reg        ret_chk_q;
  reg        ret_chk_d;
  reg  [7:0] rd_mux;

  wire       rst_n_s = rst_s2_q;
  wire       mreq_l  = ~cpu_mreq_n_i;
  wire       io_request_strobe_l  = ~io_request_strobe_n_i;
  wire       m1_l    = ~opcode_fetch_marker_n_i;
  wire       rd_l    = ~cpu_rd_n_i;
  wire       wr_l    = ~cpu_wr_n_i;
  wire       mreq_fall = mreq_l & ~mreq_l_q;
  wire       io_request_strobe_fall = io_request_strobe_l & ~io_request_strobe_l_q;
  wire       m1_fall   = m1_l & ~m1_l_q;
  wire       m1_rise   = ~m1_l & m1_l_q;
  wire [3:0] nib       = cpu_addr_i[15:12];
  wire [7:0] io_addr   = cpu_addr_i[7:0];
  wire       io_acc    = io_request_strobe_l & ~m1_l;
  wire       wr_ev     = io_acc & wr_l & ~wr_l_q;
  wire       hit_ptr   = (io_addr == `SCW_PTR_PORT);
  wire       hit_data  = (io_addr == `SCW_DATA_PORT);
  wire [1:0] mem_field = wait_ctl_q[`SCW_WC_MEM_HI:`SCW_WC_MEM_LO];
  wire [1:0] io_field  = wait_ctl_q[`SCW_WC_IO_HI:`SCW_WC_IO_LO];
  wire [1:0] dc_field  = wait_ctl_q[`SCW_WC_DC_HI:`SCW_WC_DC_LO];
  wire       mem_in_range;
  wire       ext_ok;

  // Wait states of 0, 2, 4 or 6 from a two-bit field
  function [3:0] dbl_wait;
    input [1:0] f;
    begin
      dbl_wait = {1'b0, f, 1'b0};
    end
  endfunction

  function is_onchip;
    input [7:0] a;
    begin
      is_onchip = ((a & `SCW_IO_TMR_MASK) == `SCW_IO_TMR_BASE) |
                  ((a & `SCW_IO_SER_MASK) == `SCW_IO_SER_BASE) |
                  (a == `SCW_IO_WDT_MASTER) |
                  (a == `SCW_IO_WDT_CMD) |
                  (a == `SCW_IO_INT_PRIO) |
                  (a == `SCW_PTR_PORT) |
                  (a == `SCW_DATA_PORT);
    end
  endfunction

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  scw_reset_ctl #(
    .POR_CYCLES (POR_CYCLES),
    .CNT_W      (POR_CNT_W)
  ) u_reset (
    .clk_sys_i      (clk_sys_i),
    .rst_n_i        (rst_n_s),
    .out_disable_i  (misc_q[`SCW_MC_RST_DIS]),
    .reset_pin_i    (reset_pin_i),
    .reset_pin_o    (reset_pin_o),
    .reset_pin_oe_o (reset_pin_oe_o),
    .cpu_reset_n_o  (cpu_reset_n_o)
  );

  scw_chip_select u_cs (
    .clk_sys_i              (clk_sys_i),
    .rst_n_i                (rst_n_s),
    .upper_address_nibble_i (nib),
    .bounds_i               (csb_q),
    .low_en_i               (misc_q[`SCW_MC_CS0_EN]),
    .up_en_i                (misc_q[`SCW_MC_CS1_EN]),
    .low_bank_select_n_o    (low_bank_select_n_o),
    .upper_bank_select_n_o  (upper_bank_select_n_o)
  );

  // Bus strobes share this clock; only the wait pin needs a synchroniser
  always @(posedge clk_sys_i or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ewait_s1_q <= 1'b1;
      ewait_s2_q <= 1'b1;
      mreq_l_q   <= 1'b0;
      io_request_strobe_l_q   <= 1'b0;
      m1_l_q     <= 1'b0;
      wr_l_q     <= 1'b0;
    end else begin
      ewait_s1_q <= ext_wait_n_i;
      ewait_s2_q <= ewait_s1_q;
      mreq_l_q   <= mreq_l;
      io_request_strobe_l_q   <= io_request_strobe_l;
      m1_l_q     <= m1_l;
      wr_l_q     <= wr_l;
    end
  end

  // Control registers behind the pointer and data ports
  always @(posedge clk_sys_i or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ptr_q      <= `SCW_RST_PTR;
      wait_ctl_q <= `SCW_RST_WAIT;
      mwb_q      <= `SCW_RST_MWB;
      csb_q      <= `SCW_RST_CSB;
      misc_q     <= `SCW_RST_MISC;
    end else if (wr_ev) begin
      if (hit_ptr)
        ptr_q <= cpu_data_i;
      if (hit_data) begin
        case (ptr_q)
          `SCW_IDX_WAIT: wait_ctl_q <= cpu_data_i;
          `SCW_IDX_MWB:  mwb_q      <= cpu_data_i;
          `SCW_IDX_CSB:  csb_q      <= cpu_data_i;
          `SCW_IDX_MISC: misc_q     <= cpu_data_i & `SCW_MC_WR_MASK;
          default: ;
        endcase
      end
    end
  end

  always @* begin
    rd_mux = 8'h00;
    if (hit_ptr)
      rd_mux = ptr_q;
    else begin
      case (ptr_q)
        `SCW_IDX_WAIT: rd_mux = wait_ctl_q;
        `SCW_IDX_MWB:  rd_mux = mwb_q;
        `SCW_IDX_CSB:  rd_mux = csb_q;
        `SCW_IDX_MISC: rd_mux = misc_q;
        default:       rd_mux = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_s) begin
    if (!rst_n_s)
      io_rdata_o <= 8'h00;
    else if (io_acc && rd_l && (hit_ptr || hit_data))
      io_rdata_o <= rd_mux;
  end

  assign io_rdata_en_o = io_acc & rd_l & (hit_ptr | hit_data);
  assign clock_div1_o  = misc_q[`SCW_MC_CLK_DIV1];

  assign mem_in_range = (nib <= mwb_q[7:4]) & (nib >= mwb_q[3:0]);

  // Wait sequencer: one state per kind of bus cycle
  always @* begin
    st_d      = st_q;
    cnt_d     = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    ret_chk_d = ret_chk_q;
    case (st_q)
      ST_IDLE: begin
        if (mreq_fall) begin
          st_d  = ST_MEM;
          cnt_d = (mem_in_range ? {2'b00, mem_field} : 4'h0) +
                  {3'b000, m1_l & wait_ctl_q[`SCW_WC_OPF]};
          ret_chk_d = m1_l & ed_seen_q & dc_field[1];
        end else if (m1_fall) begin
          st_d  = ST_DAISY;
          cnt_d = dbl_wait(dc_field);
        end else if (io_request_strobe_fall) begin
          st_d  = ST_IO;
          cnt_d = is_onchip(io_addr) ? 4'h0 : dbl_wait(io_field);
        end
      end
      ST_MEM: begin
        // Opcode data is taken once the programmed waits have run out;
        // that examining cycle is itself the first added wait
        if (cnt_q == 4'h0 && ret_chk_q) begin
          ret_chk_d = 1'b0;
          if (cpu_data_i == `SCW_OP_RETURN)
            cnt_d = (dc_field == 2'd3) ? 4'h3 : 4'h1;
          else
            cnt_d = 4'h0;
        end else if (!mreq_l && !m1_l) begin
          st_d      = ST_IDLE;
          ret_chk_d = 1'b0;
        end
      end
      ST_IO: begin
        if (!io_request_strobe_l)
          st_d = ST_IDLE;
      end
      ST_DAISY: begin
        if (io_request_strobe_fall) begin
          st_d  = ST_VECT;
          cnt_d = {3'b000, wait_ctl_q[`SCW_WC_VEC]};
        end else if (!m1_l) begin
          st_d = ST_IDLE;
        end
      end
      ST_VECT: begin
        if (!io_request_strobe_l && !m1_l)
          st_d = ST_IDLE;
      end
      default: begin
        st_d  = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 4'h0;
      ret_chk_q <= 1'b0;
      op_q      <= 8'h00;
      ed_seen_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      ret_chk_q <= ret_chk_d;
      if (st_q == ST_MEM && m1_l && rd_l)
        op_q <= cpu_data_i;
      // A prefix is remembered only across one opcode fetch
      if (m1_rise)
        ed_seen_q <= (st_q == ST_MEM) && (op_q == `SCW_OP_PREFIX);
    end
  end

  // Outside the daisy phase the wait pin counts only after the count ends
  assign ext_ok = ((st_q != ST_IDLE) & (cnt_q == 4'h0) & ~ret_chk_q) |
                  (st_q == ST_DAISY);
  // A pending opcode check holds the wait so the cycle cannot end unseen
  assign cpu_wait_n_o = ~((cnt_q != 4'h0) | ret_chk_q | (ext_ok & ~ewait_s2_q));

endmodule // scw_top

// ===== rtl/scw_regs.vh
`ifndef SCW_REGS_VH
`define SCW_REGS_VH
`define SCW_PTR_PORT       8'hee
`define SCW_DATA_PORT      8'hef
`define SCW_IDX_WAIT       8'h00
`define SCW_IDX_MWB        8'h01
`define SCW_IDX_CSB        8'h02
`define SCW_IDX_MISC       8'h03
`define SCW_RST_PTR        8'h00
`define SCW_RST_WAIT       8'h00
`define SCW_RST_MWB        8'hf0
`define SCW_RST_CSB        8'h0f
`define SCW_RST_MISC       8'h01
`define SCW_WC_MEM_HI      7
`define SCW_WC_MEM_LO      6
`define SCW_WC_IO_HI       5
`define SCW_WC_IO_LO       4
`define SCW_WC_DC_HI       3
`define SCW_WC_DC_LO       2
`define SCW_WC_VEC         1
`define SCW_WC_OPF         0
`define SCW_MC_CS0_EN      0
`define SCW_MC_CS1_EN      1
`define SCW_MC_RST_DIS     2
`define SCW_MC_CLK_DIV1    4
`define SCW_MC_WR_MASK     8'h1f
`define SCW_IO_TMR_BASE    8'h10
`define SCW_IO_TMR_MASK    8'hfc
`define SCW_IO_SER_BASE    8'h18
`define SCW_IO_SER_MASK    8'hf8
`define SCW_IO_WDT_MASTER  8'hf0
`define SCW_IO_WDT_CMD     8'hf1
`define SCW_IO_INT_PRIO    8'hf4
`define SCW_OP_PREFIX      8'hed
`define SCW_OP_RETURN      8'h4d
`define SCW_CLK_KHZ        125000
`define SCW_POR_MIN_MS     25
`define SCW_POR_MAX_MS     75
`define SCW_POR_CYCLES     (`SCW_POR_MIN_MS * `SCW_CLK_KHZ)
`define SCW_STRETCH_CYCLES 5'd16
`define SCW_EXT_MIN_CYCLES 3
`endif

// ===== rtl/scw_reset_ctl.v
`timescale 1ns/100ps
`include "scw_regs.vh"
module scw_reset_ctl #(
  parameter POR_CYCLES = `SCW_POR_CYCLES,
  parameter CNT_W      = 22
) (
  input  wire clk_sys_i,
  input  wire rst_n_i,
  input  wire out_disable_i,
  input  wire reset_pin_i,
  output wire reset_pin_o,
  output wire reset_pin_oe_o,
  output reg  cpu_reset_n_o
);
  reg [CNT_W-1:0] por_cnt_q;
  reg [4:0]       str_cnt_q;
  reg             pin_s1_q;
  reg             pin_s2_q;
  reg             pin_prev_q;
  reg             drive_q;
  wire            por_busy = (por_cnt_q != {CNT_W{1'b0}});
  wire            pin_fall = pin_prev_q & ~pin_s2_q & ~drive_q;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt_q     <= POR_CYCLES[CNT_W-1:0];
      str_cnt_q     <= 5'h00;
      pin_s1_q      <= 1'b0;
      pin_s2_q      <= 1'b0;
      pin_prev_q    <= 1'b0;
      drive_q       <= 1'b1;
      cpu_reset_n_o <= 1'b0;
    end else begin
      pin_s1_q   <= reset_pin_i;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
      if (por_busy)
        por_cnt_q <= por_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      // Only a fresh edge re-arms the stretch, so a held pin cannot lock up
      if (!por_busy && pin_fall && !out_disable_i)
        str_cnt_q <= `SCW_STRETCH_CYCLES;
      else if (str_cnt_q != 5'h00)
        str_cnt_q <= str_cnt_q - 5'h01;
      drive_q       <= por_busy | (str_cnt_q > 5'h01) |
                       (!por_busy && pin_fall && !out_disable_i);
      cpu_reset_n_o <= ~drive_q & pin_s2_q;
    end
  end
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_o = drive_q;
endmodule // scw_reset_ctl

// ===== rtl/scw_chip_select.v
`timescale 1ns/100ps
module scw_chip_select (
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire [3:0] upper_address_nibble_i,
  input  wire [7:0] bounds_i,
  input  wire       low_en_i,
  input  wire       up_en_i,
  output reg        low_bank_select_n_o,
  output reg        upper_bank_select_n_o
);
  wire [3:0] nib     = upper_address_nibble_i;
  wire       low_hit = (nib <= bounds_i[3:0]);
  wire       up_hit  = (nib > bounds_i[3:0]) & (nib <= bounds_i[7:4]);
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_bank_select_n_o   <= 1'b1;
      upper_bank_select_n_o <= 1'b1;
    end else begin
      low_bank_select_n_o   <= ~(low_en_i & low_hit);
      upper_bank_select_n_o <= ~(up_en_i & up_hit);
    end
  end
endmodule // scw_chip_select

// ===== tb/scw_mem_model.sv
`timescale 1ns/100ps
module scw_mem_model (
  input  wire       clk_sys_i,
  input  wire       sel_n_i,
  input  wire       mreq_n_i,
  input  wire [2:0] slow_i,
  input  wire       oe_i,
  input  wire       ext_rst_i,
  output wire       wait_n_o,
  output wire       pin_o
);
  reg [2:0] cnt_q = 3'd0;
  // Open-drain reset line: the pull-up wins once nobody pulls low
  assign pin_o = !(oe_i || ext_rst_i);
  assign wait_n_o = mreq_n_i || sel_n_i || cnt_q == 3'd0;
  always @(posedge clk_sys_i) begin
    if (mreq_n_i)
      cnt_q <= slow_i;
    else if (cnt_q != 3'd0)
      cnt_q <= cnt_q - 3'd1;
  end
endmodule // scw_mem_model

// ===== tb/scw_top_monitor.sv
`timescale 1ns/100ps
module scw_top_monitor (
  input wire        clk_sys_i,
  input wire        rst_n_i,
  input wire [15:0] cpu_addr_i,
  input wire [7:0]  cpu_data_i,
  input wire        cpu_mreq_n_i,
  input wire        io_request_strobe_n_i,
  input wire        cpu_wr_n_i,
  input wire        cpu_rd_n_i,
  input wire        opcode_fetch_marker_n_i,
  input wire        ext_wait_n_i,
  input wire        reset_pin_o,
  input wire        reset_pin_oe_o,
  input wire        cpu_wait_n_o,
  input wire [7:0]  io_rdata_o,
  input wire        low_bank_select_n_o,
  input wire        upper_bank_select_n_o
);
  reg  [7:0] ptr_q, wc_q, mw_q, cs_q, mc_q;
  reg  [4:0] hi_q;
  reg  [2:0] ok_q;
  reg        por_q, es_q;
  wire       ok = ok_q == 3'd4;
  wire [3:0] nib = cpu_addr_i[15:12];
  wire       mw_in = nib <= mw_q[7:4] && nib >= mw_q[3:0];
  wire       io_w = !io_request_strobe_n_i && !cpu_wr_n_i && opcode_fetch_marker_n_i;
  wire       dw = io_w && cpu_addr_i[7:0] == 8'hef;
  wire [7:0] rsel = ptr_q == 8'h00 ? wc_q : ptr_q == 8'h01 ? mw_q :
                    ptr_q == 8'h02 ? cs_q : ptr_q == 8'h03 ? mc_q : 8'h00;
  // Shadow registers rebuilt from port traffic only
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= 8'h00;
      wc_q  <= 8'h00;
      mw_q  <= 8'hf0;
      cs_q  <= 8'h0f;
      mc_q  <= 8'h01;
      hi_q  <= 5'd0;
      ok_q  <= 3'd0;
      por_q <= 1'b0;
      es_q  <= 1'b1;
    end else begin
      if (io_w && cpu_addr_i[7:0] == 8'hee) ptr_q <= cpu_data_i;
      if (dw && ptr_q == 8'h00) wc_q <= cpu_data_i;
      if (dw && ptr_q == 8'h01) mw_q <= cpu_data_i;
      if (dw && ptr_q == 8'h02) cs_q <= cpu_data_i;
      if (dw && ptr_q == 8'h03) mc_q <= cpu_data_i & 8'h1f;
      hi_q  <= reset_pin_oe_o ? hi_q + {4'd0, hi_q != 5'd31} : 5'd0;
      ok_q  <= ok ? ok_q : ok_q + 3'd1;
      por_q <= por_q | !reset_pin_oe_o;
      es_q  <= ext_wait_n_i;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_od_data;
    reset_pin_o == 1'b0;
  endproperty
  a_od_data: assert property (p_od_data) else $error("reset data not low");
  property p_stretch_len;
    por_q && $fell(reset_pin_oe_o) |-> hi_q == 5'd16;
  endproperty
  a_stretch_len: assert property (p_stretch_len) else $error("stretch length");
  property p_ext_wait;
    (ok && !cpu_mreq_n_i && !ext_wait_n_i)[*3] |-> !cpu_wait_n_o;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("ext wait lost");
  property p_low_sel;
    ok |-> low_bank_select_n_o == !($past(mc_q[0]) && $past(nib) <= $past(cs_q[3:0]));
  endproperty
  a_low_sel: assert property (p_low_sel) else $error("low select");
  property p_up_sel;
    ok |-> upper_bank_select_n_o == !($past(mc_q[1]) && $past(nib) > $past(cs_q[3:0])
      && $past(nib) <= $past(cs_q[7:4]));
  endproperty
  a_up_sel: assert property (p_up_sel) else $error("upper select");
  property p_mem_wait;
    ok && $fell(cpu_mreq_n_i) && opcode_fetch_marker_n_i && mw_in && wc_q[7:6] == 2'd3
      |=> (!cpu_wait_n_o)[*3];
  endproperty
  a_mem_wait: assert property (p_mem_wait) else $error("memory waits");
  property p_io_onchip;
    ok && $fell(io_request_strobe_n_i) && opcode_fetch_marker_n_i && es_q && ext_wait_n_i
      && cpu_addr_i[7:2] == 6'h04 |=> cpu_wait_n_o;
  endproperty
  a_io_onchip: assert property (p_io_onchip) else $error("on-chip io wait");
  property p_rd_data;
    ok && !io_request_strobe_n_i && !cpu_rd_n_i && opcode_fetch_marker_n_i
      && cpu_addr_i[7:0] == 8'hef |=> io_rdata_o == $past(rsel);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data");
endmodule // scw_top_monitor
bind scw_top scw_top_monitor i_mon (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_addr_i(cpu_addr_i),
  .cpu_data_i(cpu_data_i), .cpu_mreq_n_i(cpu_mreq_n_i),
  .io_request_strobe_n_i(io_request_strobe_n_i), .cpu_wr_n_i(cpu_wr_n_i),
  .cpu_rd_n_i(cpu_rd_n_i), .opcode_fetch_marker_n_i(opcode_fetch_marker_n_i),
  .ext_wait_n_i(ext_wait_n_i), .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o),
  .cpu_wait_n_o(cpu_wait_n_o), .io_rdata_o(io_rdata_o),
  .low_bank_select_n_o(low_bank_select_n_o), .upper_bank_select_n_o(upper_bank_select_n_o)
);

// ===== tb/system_control_wait_cs_reset_tb.sv
`timescale 1ns/100ps
`include "scw_regs.vh"
module system_control_wait_cs_reset_tb;
  reg         clk_sys_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [15:0] addr = 16'h0000;
  reg  [7:0]  dat = 8'h00;
  reg  [4:0]  ctl = 5'h1f;
  reg         ext_rst = 1'b0;
  reg  [2:0]  slow = 3'd0;
  reg  [31:0] rng = 32'h64595df3;
  reg  [15:0] exq[$];
  reg  [15:0] ex;
  reg  [7:0]  wc, mw, w, wcnt = 8'h00;
  reg         act = 1'b0, rseen = 1'b0;
  integer     errors = 0, comparisons = 0, cyc = 0, n, i, j;
  wire        ewait_n, pin, oe, wait_n, rd_en, cs0_n, div1, crst_n;
  wire [7:0]  rdata;
  always #4 clk_sys_i = ~clk_sys_i;
  scw_top #(.POR_CYCLES(20)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_addr_i(addr), .cpu_data_i(dat),
    .cpu_mreq_n_i(ctl[4]), .io_request_strobe_n_i(ctl[3]), .cpu_rd_n_i(ctl[2]),
    .cpu_wr_n_i(ctl[1]), .opcode_fetch_marker_n_i(ctl[0]), .ext_wait_n_i(ewait_n),
    .reset_pin_i(pin), .reset_pin_o(), .reset_pin_oe_o(oe), .cpu_reset_n_o(crst_n),
    .cpu_wait_n_o(wait_n), .io_rdata_o(rdata), .io_rdata_en_o(rd_en),
    .low_bank_select_n_o(cs0_n), .upper_bank_select_n_o(), .clock_div1_o(div1)
  );
  scw_mem_model i_mem (
    .clk_sys_i(clk_sys_i), .sel_n_i(cs0_n), .mreq_n_i(ctl[4]), .slow_i(slow),
    .oe_i(oe), .ext_rst_i(ext_rst), .wait_n_o(ewait_n), .pin_o(pin)
  );
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [7:0] rv(input [2:0] k);
    case (k)
      3'd0: rv = `SCW_RST_WAIT;
      3'd1: rv = `SCW_RST_MWB;
      3'd2: rv = `SCW_RST_CSB;
      3'd3: rv = `SCW_RST_MISC;
      default: rv = 8'h00;
    endcase
  endfunction
  function [7:0] memw(input [3:0] a, input f);
    memw = {6'h00, (a <= mw[7:4] && a >= mw[3:0]) ? wc[7:6] : 2'd0} + {7'h00, f};
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task hold;
    begin
      n = 0;
      repeat (2) @(negedge clk_sys_i);
      while (wait_n !== 1'b1 && n < 40) begin
        @(negedge clk_sys_i);
        n = n + 1;
      end
    end
  endtask
  // Kinds: 0 memory read, 1 fetch, 2 io write, 3 io read, 4 interrupt acknowledge
  task bus(input [2:0] k, input [15:0] a, input [7:0] d, input [15:0] e);
    begin
      exq.push_back(e);
      @(posedge clk_sys_i);
      addr <= a;
      dat <= d;
      ctl <= {k > 3'd1, k != 3'd2 && k != 3'd3, k == 3'd2 || k == 3'd4, k != 3'd2,
              k != 3'd1 && k != 3'd4};
      hold;
      if (k == 3'd4) begin
        @(posedge clk_sys_i);
        ctl[3] <= 1'b0;
        hold;
      end
      @(posedge clk_sys_i);
      ctl <= 5'h1f;
    end
  endtask
  task setr(input [7:0] k, input [7:0] v);
    begin
      bus(2, 16'h00ee, k, 16'h0000);
      bus(2, 16'h00ef, v, 16'h0000);
    end
  endtask
  task pulse(input [7:0] e);
    begin
      w = 8'h00;
      for (j = 0; j < 30; j = j + 1) begin
        @(posedge clk_sys_i);
        ext_rst <= j < 3;
        @(negedge clk_sys_i);
        if (oe === 1'b1) w = w + 8'd1;
      end
      check({8'h00, w}, {8'h00, e});
    end
  endtask
  // Result watcher: one note per finished bus cycle
  always @(negedge clk_sys_i) begin
    if (ctl != 5'h1f) begin
      act = 1'b1;
      if (wait_n === 1'b0) wcnt = wcnt + 8'd1;
      if (rd_en === 1'b1) rseen = 1'b1;
    end else if (act) begin
      ex = exq.pop_front();
      check({wcnt, rseen ? rdata : 8'h00}, ex);
      act = 1'b0;
      rseen = 1'b0;
      wcnt = 8'h00;
    end
  end
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    n = 0;
    while (oe !== 1'b0 && n < 200) begin
      @(posedge clk_sys_i);
      n = n + 1;
    end
    repeat (8) @(posedge clk_sys_i);
    check({15'h0000, crst_n}, 16'h0001);
    for (i = 0; i < 5; i = i + 1) begin
      bus(2, 16'h00ee, i[7:0], 16'h0000);
      bus(3, 16'h00ef, 8'h00, {8'h00, rv(i[2:0])});
    end
    bus(3, 16'h00ee, 8'h00, 16'h0004);
    for (i = 0; i < 8; i = i + 1) begin
      rng = xs(rng);
      wc = rng[7:0];
      mw = rng[15:8];
      setr(0, wc);
      setr(1, mw);
      setr(2, rng[23:16]);
      setr(3, {6'h00, rng[25:24]});
      bus(3, 16'h00ef, 8'h00, {14'h0000, rng[25:24]});
      for (j = 0; j < 4; j = j + 1) begin
        rng = xs(rng);
        bus(0, rng[15:0], 8'h00, {memw(rng[15:12], 1'b0), 8'h00});
        bus(1, rng[31:16], 8'h00, {memw(rng[31:28], wc[0]), 8'h00});
        bus(2, {11'h002, rng[4:0]}, rng[7:0], {5'h00, wc[5:4], 9'h000});
        bus(4, 16'h0000, 8'h00, {5'h00, wc[3:2], wc[1], 8'h00});
        bus(3, {8'h00, j == 0 ? 8'h10 : j == 1 ? 8'h13 : j == 2 ? 8'h1f : 8'hf4},
            8'h00, 16'h0000);
      end
    end
    setr(0, 8'hc0);
    setr(1, 8'hf0);
    setr(2, 8'h0f);
    setr(3, 8'h01);
    bus(0, 16'h1234, 8'h00, 16'h0300);
    slow <= 3'd5;
    bus(0, 16'h8000, 8'h00, 16'h0600);
    slow <= 3'd0;
    for (i = 2; i < 4; i = i + 1) begin
      setr(0, {4'h0, i[1:0], 2'b00});
      bus(1, 16'h0100, 8'hed, 16'h0000);
      bus(1, 16'h0101, 8'h4d, {5'h00, i[1:0] - 2'd1, 9'h000});
      bus(1, 16'h0102, 8'hed, 16'h0000);
      bus(1, 16'h0103, 8'h3e, 16'h0100);
    end
    pulse(8'd16);
    setr(3, 8'hf5);
    bus(3, 16'h00ef, 8'h00, 16'h0015);
    check({15'h0000, div1}, 16'h0001);
    pulse(8'd0);
    report_and_stop;
  end
endmodule // system_control_wait_cs_reset_tb
